// ===== bench/tb_clock_timer_with_read_hold.sv
// Self-checking testbench of the clock timer with read hold.
`timescale 1ns/100ps
`include "ctm_regs.svh"

module tb_clock_timer_with_read_hold;
	localparam int HOLD = 8;
	logic core_clk_i = 1'b0;
	logic nrst_i = 1'b0;
	logic ce_i = 1'b1;
	logic osc_tick_i = 1'b0;
	ctm_pkg::ctm_apb_req_t apb_req_i = '0;
	ctm_pkg::ctm_apb_rsp_t apb_rsp_o;
	logic [7:0] count_o;
	logic irq_o;
	int num_errors = 0;
	int checked = 0;
	int cycles = 0;
	logic [31:0] rd;
	logic err;

	// A short hold timeout keeps the hold scenarios quick.
	ctm_clock_timer #(.HOLD_CYCLES(HOLD)) dut (
		.core_clk_i(core_clk_i),
		.nrst_i(nrst_i),
		.ce_i(ce_i),
		.osc_tick_i(osc_tick_i),
		.apb_req_i(apb_req_i),
		.apb_rsp_o(apb_rsp_o),
		.count_o(count_o),
		.irq_o(irq_o)
	);

	// The clock toggles every half period of 5 ns.
	always #5 core_clk_i = ~core_clk_i;

	// Watchdog: the whole run needs far fewer cycles, so a hang is cut here.
	always @(posedge core_clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 6000) begin
			num_errors++;
			finish_test();
		end
	end

	task automatic finish_test();
		$display("Comparisons %0d, mismatches %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
		end
	endtask

	// One APB transfer; the request is held until pready is sampled high.
	task automatic apb(input logic wr, input logic [15:0] idx, input logic [31:0] wd);
		apb_req_i <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: {idx, 2'b00}, pwdata: wd};
		@(posedge core_clk_i);
		apb_req_i.penable <= 1'b1;
		// The wait has no timeout of its own; a hang is left to the watchdog.
		do begin
			@(posedge core_clk_i);
		end while (apb_rsp_o.pready !== 1'b1);
		rd = apb_rsp_o.prdata;
		err = apb_rsp_o.pslverr;
		apb_req_i <= '0;
		@(posedge core_clk_i);
	endtask

	task automatic rdc(input logic [15:0] idx, input logic [31:0] exp);
		apb(1'b0, idx, 32'h0000_0000);
		check(rd, exp);
	endtask

	task automatic wrr(input logic [15:0] idx, input logic [31:0] d);
		apb(1'b1, idx, d);
	endtask

	// Prescaler pulses of one cycle each, with a gap so every step lands.
	task automatic tick(input int n);
		repeat (n) begin
			osc_tick_i <= 1'b1;
			@(posedge core_clk_i);
			osc_tick_i <= 1'b0;
			@(posedge core_clk_i);
		end
	endtask

	// The request output is registered, so two edges pass before it is judged.
	task automatic chk_irq(input logic exp);
		repeat (2) @(posedge core_clk_i);
		check({31'h0, irq_o}, {31'h0, exp});
	endtask

	task automatic t_reset();
		check({24'h0, count_o}, 32'h0000_0000);
		rdc(`CTM_IDX_CTRL, 32'h0000_0000);
		rdc(`CTM_IDX_FLAG, 32'h0000_0000);
		rdc(`CTM_IDX_MASK, 32'h0000_0000);
		rdc(16'hff7d, 32'h0000_0000);
		check({31'h0, err}, 32'h0000_0001);
	endtask

	task automatic t_run();
		tick(3);
		check({24'h0, count_o}, 32'h0000_0000);
		wrr(`CTM_IDX_CTRL, 32'h0000_0001);
		tick(19);
		rdc(`CTM_IDX_LOW, 32'h0000_0003);
		rdc(`CTM_IDX_HIGH, 32'h0000_0001);
		check({24'h0, count_o}, 32'h0000_0013);
		wrr(`CTM_IDX_CTRL, 32'h0000_0001);
		check({24'h0, count_o}, 32'h0000_0013);
		wrr(`CTM_IDX_CTRL, 32'h0000_0003);
		check({24'h0, count_o}, 32'h0000_0000);
		rdc(`CTM_IDX_CTRL, 32'h0000_0001);
	endtask

	// The carry lands inside the hold, then release by read, timeout, and no hold.
	task automatic t_hold();
		tick(31);
		rdc(`CTM_IDX_LOW, 32'h0000_000f);
		tick(1);
		check({24'h0, count_o}, 32'h0000_0010);
		rdc(`CTM_IDX_HIGH, 32'h0000_0001);
		check({24'h0, count_o}, 32'h0000_0020);
		tick(15);
		rdc(`CTM_IDX_LOW, 32'h0000_000f);
		tick(1);
		check({24'h0, count_o}, 32'h0000_0020);
		repeat (HOLD + 2) @(posedge core_clk_i);
		check({24'h0, count_o}, 32'h0000_0030);
		tick(15);
		rdc(`CTM_IDX_HIGH, 32'h0000_0003);
		tick(1);
		check({24'h0, count_o}, 32'h0000_0040);
	endtask

	// Each stage ends on the falling edge of the next interrupt tap.
	task automatic t_flags();
		int steps[4] = '{8, 24, 96, 128};
		logic [3:0] exp[4] = '{4'h1, 4'h3, 4'h7, 4'hf};
		wrr(`CTM_IDX_CTRL, 32'h0000_0003);
		wrr(`CTM_IDX_FLAG, 32'h0000_000f);
		rdc(`CTM_IDX_FLAG, 32'h0000_0000);
		for (int i = 0; i < 4; i++) begin
			tick(steps[i]);
			rdc(`CTM_IDX_FLAG, {28'h0, exp[i]});
			chk_irq(1'b0);
		end
		wrr(`CTM_IDX_MASK, 32'h0000_0001);
		chk_irq(1'b1);
		wrr(`CTM_IDX_FLAG, 32'h0000_0001);
		rdc(`CTM_IDX_FLAG, 32'h0000_000e);
		chk_irq(1'b0);
		wrr(`CTM_IDX_MASK, 32'h0000_0008);
		chk_irq(1'b1);
	endtask

	// Reset for six cycles, then run every scenario in turn.
	initial begin
		repeat (6) @(posedge core_clk_i);
		nrst_i <= 1'b1;
		@(posedge core_clk_i);
		t_reset();
		t_run();
		t_hold();
		t_flags();
		finish_test();
	end
endmodule

// ===== hw/ctm_clock_timer.sv
// Clock timer: 8-bit tap counter with read hold, edge flags, masks and an APB slave.
`timescale 1ns/100ps
`include "ctm_regs.svh"

module ctm_clock_timer #(
	parameter int HOLD_CYCLES = `CTM_HOLD_CYCLES
) (
	// Clock, reset and freeze.
	input wire logic core_clk_i,
	input wire logic nrst_i,
	input wire logic ce_i,
	// Divided oscillator tick from the prescaler, same clock domain.
	input wire logic osc_tick_i,
	// APB slave port.
	input wire ctm_pkg::ctm_apb_req_t apb_req_i,
	output ctm_pkg::ctm_apb_rsp_t apb_rsp_o,
	// Counter value and masked interrupt request.
	output logic [7:0] count_o,
	output logic irq_o
);

	ctm_pkg::ctm_state_t s_q;
	ctm_pkg::ctm_state_t s_d;

	logic setup;
	logic access;
	logic aligned;
	logic [15:0] idx;
	logic wr_ctrl;
	logic wr_flag;
	logic wr_mask;
	logic clr_wr;
	logic rd_low_setup;
	logic rd_high_setup;
	logic held_now;
	logic tick;
	logic carry;
	logic release_hold;
	logic [7:0] cnt_n;
	logic [7:0] fall8;
	logic [3:0] fall;
	logic [31:0] rd_data;
	logic rd_err;

	// Bus phase decode; misaligned addresses are treated as unmapped.
	assign setup = apb_req_i.psel & ~apb_req_i.penable;
	assign access = apb_req_i.psel & apb_req_i.penable & s_q.rsp.pready;
	assign idx = apb_req_i.paddr[17:2];
	assign aligned = (apb_req_i.paddr[1:0] == 2'h0);

	// Write strobes take effect only at the completing access edge.
	assign wr_ctrl = access & apb_req_i.pwrite & aligned & (idx == `CTM_IDX_CTRL);
	assign wr_flag = access & apb_req_i.pwrite & aligned & (idx == `CTM_IDX_FLAG);
	assign wr_mask = access & apb_req_i.pwrite & aligned & (idx == `CTM_IDX_MASK);
	assign clr_wr = wr_ctrl & apb_req_i.pwdata[`CTM_CTRL_CLR_BIT]; // [RULE14]

	// Reads are sampled at setup, so the hold must start on that same edge.
	// Otherwise a carry landing between setup and access would tear the pair.
	assign rd_low_setup = setup & ~apb_req_i.pwrite & aligned & (idx == `CTM_IDX_LOW); // [RULE5]
	assign rd_high_setup = setup & ~apb_req_i.pwrite & aligned & (idx == `CTM_IDX_HIGH);

	// Holding covers the cycle of the low read itself as well.
	assign held_now = (s_q.hold == ctm_pkg::CTM_HELD) | rd_low_setup; // [RULE5]

	// The low nibble only steps while running.
	assign tick = osc_tick_i & s_q.run; // [RULE15]
	assign carry = tick & (s_q.cnt[3:0] == 4'hf); // [RULE4]

	// Hold ends on the high read or when the timeout count is reached.
	// A high read with no earlier low read finds the hold free and changes nothing.
	// A low read at the timeout edge restarts the hold instead, so a pending carry lands once.
	assign release_hold = (s_q.hold == ctm_pkg::CTM_HELD) & ~rd_low_setup &
		(rd_high_setup | (s_q.hold_cnt == 20'(HOLD_CYCLES - 1))); // [RULE6] [RULE7]

	// Register read multiplexer.
	always_comb begin
		rd_data = 32'h0000_0000;
		rd_err = 1'b0;
		if (!aligned) begin
			rd_err = 1'b1;
		end else if (idx == `CTM_IDX_CTRL) begin
			// The clear bit is write-only and always reads as zero.
			rd_data[`CTM_CTRL_RUN_BIT] = s_q.run; // [RULE14]
		end else if (idx == `CTM_IDX_LOW) begin
			rd_data[3:0] = s_q.cnt[3:0]; // [RULE2] [RULE3]
		end else if (idx == `CTM_IDX_HIGH) begin
			rd_data[3:0] = s_q.cnt[7:4]; // [RULE2] [RULE3]
		end else if (idx == `CTM_IDX_FLAG) begin
			rd_data[3:0] = s_q.flags;
		end else if (idx == `CTM_IDX_MASK) begin
			rd_data[3:0] = s_q.mask;
		end else begin
			rd_err = 1'b1;
		end
	end

	// Next counter value before any clear; the taps of an RC source run faster alike.
	always_comb begin
		cnt_n = s_q.cnt;
		if (tick) begin
			cnt_n[3:0] = s_q.cnt[3:0] + 4'h1; // [RULE1] [RULE13]
		end
		if ((carry & ~held_now) | (release_hold & (s_q.pend | carry))) begin
			cnt_n[7:4] = s_q.cnt[7:4] + 4'h1; // [RULE4] [RULE5]
		end
	end

	// Falling edges of the four interrupt taps; a clear makes no events.
	assign fall8 = s_q.cnt & ~cnt_n & {8{~clr_wr}};
	assign fall = {fall8[`CTM_TAP_1HZ], fall8[`CTM_TAP_2HZ],
		fall8[`CTM_TAP_8HZ], fall8[`CTM_TAP_32HZ]}; // [RULE9] [RULE10]

	// Next-state logic for the whole timer.
	always_comb begin
		s_d = s_q;

		// Bus answer: ready one cycle after setup, data and error captured then.
		s_d.rsp.pready = 1'b0;
		if (setup) begin
			s_d.rsp.pready = 1'b1;
			s_d.rsp.prdata = apb_req_i.pwrite ? 32'h0000_0000 : rd_data;
			s_d.rsp.pslverr = rd_err;
		end

		// Run control.
		if (wr_ctrl) begin
			s_d.run = apb_req_i.pwdata[`CTM_CTRL_RUN_BIT]; // [RULE15]
		end

		// Counter, with clear winning over a tick in the same cycle.
		s_d.cnt = cnt_n;
		if (clr_wr) begin
			s_d.cnt = `CTM_CNT_RST; // [RULE14]
		end

		// Hold state machine.
		case (s_q.hold)
			ctm_pkg::CTM_FREE: begin
				if (rd_low_setup) begin
					s_d.hold = ctm_pkg::CTM_HELD; // [RULE5]
					s_d.hold_cnt = 20'h00000;
					s_d.pend = carry;
				end
			end
			ctm_pkg::CTM_HELD: begin
				if (rd_low_setup) begin
					// A repeated low read restarts the timeout.
					s_d.hold_cnt = 20'h00000;
					s_d.pend = s_q.pend | carry;
				end else if (release_hold) begin
					s_d.hold = ctm_pkg::CTM_FREE; // [RULE6]
					s_d.pend = 1'b0;
				end else begin
					s_d.hold_cnt = s_q.hold_cnt + 20'h00001;
					s_d.pend = s_q.pend | carry;
				end
			end
			default: begin
				s_d.hold = ctm_pkg::CTM_FREE;
			end
		endcase
		// A cleared counter has no carry left to deliver.
		if (clr_wr) begin
			s_d.pend = 1'b0;
		end

		// Flags: write one clears, and a new edge wins over the clear.
		s_d.flags = s_q.flags;
		if (wr_flag) begin
			s_d.flags = s_q.flags & ~apb_req_i.pwdata[3:0];
		end
		s_d.flags = s_d.flags | fall; // [RULE10] [RULE12]

		// Masks.
		if (wr_mask) begin
			s_d.mask = apb_req_i.pwdata[3:0]; // [RULE11]
		end

		// Request is high while any unmasked flag stands.
		s_d.irq = |(s_d.flags & s_d.mask); // [RULE11]
	end

	// State register; a low clock enable freezes everything, bus answer included.
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			s_q.cnt <= `CTM_CNT_RST;
			s_q.run <= `CTM_RUN_RST;
			s_q.hold <= ctm_pkg::CTM_FREE;
			s_q.pend <= 1'b0;
			s_q.hold_cnt <= 20'h00000;
			s_q.flags <= `CTM_FLAG_RST;
			s_q.mask <= `CTM_MASK_RST;
			s_q.irq <= 1'b0;
			s_q.rsp.pready <= 1'b0;
			s_q.rsp.prdata <= 32'h0000_0000;
			s_q.rsp.pslverr <= 1'b0;
		end else if (ce_i) begin
			s_q <= s_d;
		end
	end

	// Outputs straight from the state register.
	assign apb_rsp_o = s_q.rsp;
	assign count_o = s_q.cnt;
	assign irq_o = s_q.irq;

	// Checks on the timer behaviour.
	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (!nrst_i);

	// Clear write zeroes the counter on the next edge.
	chk_clear_zeroes_count: assert property ( // [RULE14]
		(ce_i && clr_wr) |=> (s_q.cnt == `CTM_CNT_RST)
	) else $error("counter not zero after clear write");

	// A stopped counter stands still unless cleared or released from a hold.
	chk_stopped_count_stable: assert property ( // [RULE15]
		(ce_i && !s_q.run && !clr_wr && !release_hold)
		|=> (s_q.cnt == $past(s_q.cnt))
	) else $error("counter moved while stopped");

	// Each running tick steps the low nibble by one.
	chk_low_nibble_step: assert property ( // [RULE1]
		(ce_i && osc_tick_i && s_q.run && !clr_wr)
		|=> (s_q.cnt[3:0] == $past(s_q.cnt[3:0]) + 4'h1)
	) else $error("low nibble did not step on tick");

	// A free overflow carries into the high nibble.
	chk_carry_into_high: assert property ( // [RULE4]
		(ce_i && carry && !held_now && !clr_wr)
		|=> (s_q.cnt[7:4] == $past(s_q.cnt[7:4]) + 4'h1)
	) else $error("carry lost into high nibble");

	// While held and not releasing, the high nibble does not move.
	chk_high_held_stable: assert property ( // [RULE5]
		(ce_i && held_now && !release_hold && !clr_wr)
		|=> $stable(s_q.cnt[7:4])
	) else $error("high nibble moved while held");

	// The hold never outlasts its timeout count.
	chk_hold_bounded: assert property ( // [RULE6]
		(s_q.hold == ctm_pkg::CTM_HELD) |-> (s_q.hold_cnt < 20'(HOLD_CYCLES))
	) else $error("hold ran past its timeout");

	// A high read without a prior hold starts none.
	chk_high_first_free: assert property ( // [RULE7]
		(ce_i && rd_high_setup && s_q.hold == ctm_pkg::CTM_FREE)
		|=> (s_q.hold == ctm_pkg::CTM_FREE)
	) else $error("high read started a hold");

	// Tap edges set their flags whatever the mask.
	chk_edge_sets_flag: assert property ( // [RULE12]
		(ce_i && (fall != 4'h0)) |=> ((s_q.flags & $past(fall)) == $past(fall))
	) else $error("tap edge failed to set flag");

	// Request follows flags gated by masks.
	chk_irq_follows_mask: assert property ( // [RULE11]
		s_q.irq == |(s_q.flags & s_q.mask)
	) else $error("request disagrees with flags and masks");

	// The clear bit reads back as zero.
	chk_clear_reads_zero: assert property ( // [RULE14]
		(ce_i && setup && !apb_req_i.pwrite && idx == `CTM_IDX_CTRL)
		|=> (s_q.rsp.prdata[`CTM_CTRL_CLR_BIT] == 1'b0)
	) else $error("clear bit read back as one");

	// A low read enters the hold with a fresh timeout.
	chk_low_read_holds: assert property ( // [RULE5]
		(ce_i && rd_low_setup)
		|=> (s_q.hold == ctm_pkg::CTM_HELD && s_q.hold_cnt == 20'h00000)
	) else $error("low read did not start the hold");

	// A carry that meets the hold is remembered, not lost.
	chk_carry_kept_pending: assert property ( // [RULE5]
		(ce_i && carry && held_now && !release_hold && !clr_wr)
		|=> s_q.pend
	) else $error("carry during hold was dropped");

	// Reading the high nibble ends a running hold.
	chk_high_read_releases: assert property ( // [RULE6]
		(ce_i && rd_high_setup && s_q.hold == ctm_pkg::CTM_HELD)
		|=> (s_q.hold == ctm_pkg::CTM_FREE)
	) else $error("high read left the hold standing");

	// The timeout ends the hold when no new low read restarts it.
	chk_timeout_releases: assert property ( // [RULE6]
		(ce_i && s_q.hold == ctm_pkg::CTM_HELD && !rd_low_setup &&
		s_q.hold_cnt == 20'(HOLD_CYCLES - 1))
		|=> (s_q.hold == ctm_pkg::CTM_FREE)
	) else $error("hold survived its timeout");

	// The release edge delivers a remembered or fresh carry exactly once.
	chk_release_applies_carry: assert property ( // [RULE6]
		(ce_i && release_hold && (s_q.pend || carry) && !clr_wr)
		|=> (s_q.cnt[7:4] == $past(s_q.cnt[7:4]) + 4'h1)
	) else $error("release did not apply the carry");

	// After a release nothing is left pending.
	chk_release_clears_pend: assert property ( // [RULE6]
		(ce_i && release_hold)
		|=> !s_q.pend
	) else $error("carry still pending after release");

	// The high nibble moves only on a carry or a release with a pending carry.
	chk_high_only_on_carry: assert property ( // [RULE4]
		(ce_i && !carry && !(release_hold && s_q.pend) && !clr_wr)
		|=> $stable(s_q.cnt[7:4])
	) else $error("high nibble moved without a carry");

	// The low nibble moves only on a running tick.
	chk_low_only_on_tick: assert property ( // [RULE15]
		(ce_i && !tick && !clr_wr)
		|=> $stable(s_q.cnt[3:0])
	) else $error("low nibble moved without a tick");

	// The run bit takes the written value.
	chk_run_follows_write: assert property ( // [RULE15]
		(ce_i && wr_ctrl)
		|=> (s_q.run == $past(apb_req_i.pwdata[`CTM_CTRL_RUN_BIT]))
	) else $error("run bit did not follow the write");

	// Clearing the counter makes no tap edges.
	chk_clear_makes_no_flag: assert property ( // [RULE14]
		(ce_i && clr_wr)
		|=> (s_q.flags == $past(s_q.flags))
	) else $error("clear write changed the flags");

	// A flag rises only on its own tap edge.
	chk_flag_needs_edge: assert property ( // [RULE10]
		ce_i
		|=> ((s_q.flags & ~$past(s_q.flags) & ~$past(fall)) == 4'h0)
	) else $error("flag set without a tap edge");

	// The mask register takes the written value.
	chk_mask_follows_write: assert property ( // [RULE11]
		(ce_i && wr_mask)
		|=> (s_q.mask == $past(apb_req_i.pwdata[3:0]))
	) else $error("mask did not follow the write");

	// A high read returns the upper four counter bits.
	chk_high_read_data: assert property ( // [RULE3]
		(ce_i && rd_high_setup)
		|=> (s_q.rsp.prdata == {28'h0000000, $past(s_q.cnt[7:4])})
	) else $error("high read returned wrong data");

	// A low read returns the lower four counter bits.
	chk_low_read_data: assert property ( // [RULE3]
		(ce_i && rd_low_setup)
		|=> (s_q.rsp.prdata == {28'h0000000, $past(s_q.cnt[3:0])})
	) else $error("low read returned wrong data");

endmodule

// ===== hw/ctm_pkg.sv
// Types shared by the clock timer: bus carriers, hold states and the module state.
package ctm_pkg;

	// High-nibble hold state, one bit so the codes are trivially Gray.
	typedef enum logic [0:0] {
		CTM_FREE = 1'b0,
		CTM_HELD = 1'b1
	} ctm_hold_st_t;

	// APB request from the master.
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [17:0] paddr;
		logic [31:0] pwdata;
	} ctm_apb_req_t;

	// APB answer to the master.
	typedef struct packed {
		logic pready;
		logic [31:0] prdata;
		logic pslverr;
	} ctm_apb_rsp_t;

	// Whole state of the timer.
	typedef struct packed {
		logic [7:0] cnt;
		logic run;
		ctm_hold_st_t hold;
		logic pend;
		logic [19:0] hold_cnt;
		logic [3:0] flags;
		logic [3:0] mask;
		logic irq;
		ctm_apb_rsp_t rsp;
	} ctm_state_t;

endpackage

// ===== hw/ctm_regs.svh
// Register indices, field positions, reset values and timing counts of the clock timer.
// Contract
// RULE1: The timer is an 8-bit binary counter stepped by the divided oscillator tick.
// RULE2: Software reads the counter; low nibble holds 128-16 Hz, high nibble 8-1 Hz.
// RULE3: Low nibble sits at the first index, high nibble at the next index.
// RULE4: The high nibble advances on a carry when the low nibble overflows from ones.
// RULE5: Reading the low nibble suspends carry increments of the high nibble.
// RULE6: The hold ends on the high nibble read or after the hold timeout.
// RULE7: Reading the high nibble first triggers no hold of either nibble.
// RULE8: Software reads the low nibble before the high nibble for a coherent value.
// RULE9: Falling edges of the 32, 8, 2 and 1 Hz taps are interrupt events.
// RULE10: Each such edge sets its own flag, bits zero to three in that order.
// RULE11: Each of the four sources has a mask bit gating the interrupt request.
// RULE12: A flag is set on its edge regardless of its mask bit.
// RULE13: With an RC source near 60 kHz the taps scale and suit no timekeeping.
// RULE14: Writing one to the clear bit zeroes the counter; zero does nothing; reads zero.
// RULE15: The counter advances only while the run bit is one; run resets to zero. A hold release still adds a pending carry while stopped.
`ifndef CTM_REGS_SVH
`define CTM_REGS_SVH

// Register indices; the byte address is four times the index.
`define CTM_IDX_CTRL 16'hff78
`define CTM_IDX_LOW 16'hff79
`define CTM_IDX_HIGH 16'hff7a
`define CTM_IDX_FLAG 16'hff7b
`define CTM_IDX_MASK 16'hff7c

// Control register fields.
`define CTM_CTRL_RUN_BIT 0
`define CTM_CTRL_CLR_BIT 1

// Counter bit positions of the interrupt taps.
`define CTM_TAP_32HZ 2
`define CTM_TAP_8HZ 4
`define CTM_TAP_2HZ 6
`define CTM_TAP_1HZ 7

// Reset values.
`define CTM_CNT_RST 8'h00
`define CTM_FLAG_RST 4'h0
`define CTM_MASK_RST 4'h0
`define CTM_RUN_RST 1'b0

// Hold timeout: shortest documented hold, rounded up to whole core cycles.
`define CTM_CLK_PERIOD_NS 10
`define CTM_HOLD_TIME_NS 480000
`define CTM_HOLD_CYCLES ((`CTM_HOLD_TIME_NS + `CTM_CLK_PERIOD_NS - 1) / `CTM_CLK_PERIOD_NS)

`endif
